//--- dv/sadc_host_model.sv
// Serial host that frames conversions and captures the result line.
// Assumes the bench calls frame() and keeps sample_code stable meanwhile.
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
   input  wire logic sys_clk,
   input  wire logic serial_result_out,
   input  wire logic serial_result_oe_n,
   output var logic  chip_sel_n,
   output var logic  link_sclk
);
   logic base_clk = 1'b0;
   logic last_q   = 1'b0;
   logic line;
   always #6 base_clk = ~base_clk;
   // Released line shows the inverse of its last level, never a kind default
   always @(posedge sys_clk) if (!serial_result_oe_n) last_q <= serial_result_out;
   assign line = serial_result_oe_n ? ~last_q : serial_result_out;
   initial begin
      chip_sel_n = 1'b1;
      link_sclk  = 1'b1;
   end
   // Slow serial clock: the design copies bits at sys_clk rate
   task automatic half();
      repeat (14) @(posedge base_clk);
   endtask
   task automatic frame(input int n_fall, output logic [15:0] bits);
      bits = 16'h0000;
      chip_sel_n <= 1'b0;
      half();
      for (int i = 0; i < n_fall; i++) begin
         link_sclk <= 1'b0;
         half();
         link_sclk <= 1'b1;
         bits = {bits[14:0], line};
         half();
      end
      chip_sel_n <= 1'b1;
      repeat (112) @(posedge base_clk);
   endtask
endmodule // sadc_host_model
`default_nettype wire

//--- dv/sadc_monitor.sv
// Port checker for the converter frame control.
// Assumes binding onto sadc_frame_ctrl and a free-running sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sadc_monitor (
   input wire logic                   sys_clk,
   input wire logic                   srst,
   input wire logic                   chip_sel_n,
   input wire logic                   serial_result_out,
   input wire logic                   serial_result_oe_n,
   input wire logic                   analog_power_on,
   input wire logic                   sample_hold,
   input wire sadc_pkg::sadc_status_t status
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_sel_fall; $fell(chip_sel_n); endsequence
   sequence s_sel_idle; chip_sel_n [*5]; endsequence
   a_rst_clear: assert property (disable iff (1'b0) srst ##1 srst |->
      serial_result_oe_n && !analog_power_on) else $error("outputs not cleared in reset");
   a_power_follow: assert property (s_sel_fall |-> ##[1:4] analog_power_on)
      else $error("select fall did not power up");
   a_sel_release: assert property (
      s_sel_fall |-> ##[1:4] (!serial_result_oe_n && sample_hold)) else $error("no release");
   a_rise_tristate: assert property ($rose(chip_sel_n) |-> ##[1:4] serial_result_oe_n)
      else $error("output driven after select rise");
   a_idle_release: assert property (s_sel_idle |-> serial_result_oe_n)
      else $error("output driven while idle");
   a_lead_zeros: assert property (s_sel_fall |-> ##4 (!serial_result_out) [*4])
      else $error("leading bits not zero");
   a_shut_hold: assert property (s_sel_idle ##0 !analog_power_on |=> !analog_power_on)
      else $error("left shutdown without select fall");
   a_valid_power: assert property ($rose(status.result_valid) |->
      analog_power_on && status.powered) else $error("valid result while unpowered");
endmodule // sadc_monitor
bind sadc_frame_ctrl sadc_monitor i_sadc_monitor (.sys_clk, .srst, .chip_sel_n,
   .serial_result_out, .serial_result_oe_n, .analog_power_on, .sample_hold, .status);
`default_nettype wire

//--- dv/test_serial_adc_frame_power_control.sv
// Self-checking bench for the converter frame and power-mode control.
// Assumes the host model paces frames; expectations come from the frame shape.
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_frame_power_control;
   logic                   sys_clk = 1'b0;
   logic                   srst    = 1'b1;
   sadc_pkg::sadc_code_t   code    = 10'h000;
   logic                   chip_sel_n, link_sclk, sd_out, sd_oe_n, pwr, hold;
   sadc_pkg::sadc_status_t status;
   logic [15:0]            bits;
   int                     miscompares = 0;
   int                     comparisons = 0;
   always #20 sys_clk = ~sys_clk;
   sadc_frame_ctrl i_sadc_frame_ctrl (.sys_clk, .srst, .link_sclk, .chip_sel_n,
      .sample_code(code), .serial_result_out(sd_out), .serial_result_oe_n(sd_oe_n),
      .analog_power_on(pwr), .sample_hold(hold), .status);
   sadc_host_model i_sadc_host_model (.sys_clk, .serial_result_out(sd_out),
      .serial_result_oe_n(sd_oe_n), .chip_sel_n, .link_sclk);
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Either alignment of the optional extra leading zero is accepted
   function automatic logic word_ok(input logic [15:0] w, input sadc_pkg::sadc_code_t c);
      return (w[15:1] === {2'h0, c, 3'h0}) || (w[15:1] === {3'h0, c, 2'h0});
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic run(input int n, input sadc_pkg::sadc_code_t c, input string name);
      @(posedge sys_clk) code <= c;
      i_sadc_host_model.frame(n, bits);
      @(posedge sys_clk);
      $display("test %s done", name);
   endtask
   task automatic full_frames(input int n);
      sadc_pkg::sadc_code_t c;
      for (int i = 0; i < n; i++) begin
         c = (i == 0) ? 10'h001 : (i == 1) ? 10'h3FF : 10'($urandom);
         run(16, c, "full frame");
         check_val("frame bits", 16'h0001, {15'h0000, word_ok(bits, c)});
         check_val("status", 16'h0007, {13'h0000, status});
         check_val("oe_n idle", 16'h0001, {15'h0000, sd_oe_n});
      end
   endtask
   initial begin
      void'($urandom(32'h0000_6656));
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check_val("reset power", 16'h0000, {15'h0000, pwr});
      run(16, 10'h200, "wake-up");
      check_val("wake status", 16'h0006, {13'h0000, status});
      full_frames(6);
      run(12, 10'h155, "truncate");
      check_val("trunc power", 16'h0001, {15'h0000, pwr});
      check_val("trunc oe_n", 16'h0001, {15'h0000, sd_oe_n});
      run(5, 10'h2AA, "shutdown");
      check_val("shut power", 16'h0000, {15'h0000, pwr});
      check_val("shut mode", 16'h0000, {15'h0000, status.normal_mode});
      run(16, 10'h0F0, "re-wake");
      check_val("rewake status", 16'h0006, {13'h0000, status});
      full_frames(2);
      end_of_test();
   end
   initial begin
      #500us;
      miscompares++;
      end_of_test();
   end
endmodule // test_serial_adc_frame_power_control
`default_nettype wire

//--- hw/sadc_frame_ctrl.sv
// Frame and power-mode control of a serial-output 10-bit converter.
// Assumes the host drives chip select and serial clock; the analog core
// delivers a straight-binary code on sample_code.
//
// How it works
// - Result is a 10-bit straight binary code, step equals supply over 1024.
// - Chip select falling enters normal mode and starts a conversion.
// - Chip select high before tenth falling edge enters shutdown.
// - Shutdown holds until chip select falls again; analog core is off.
// - Rise between 10th and 16th edge aborts, stays normal, tristates output.
// - After sixteen clocks the result output returns to high impedance.
// - Select fall in shutdown powers up; first result unusable, second valid.
// - Hold select past tenth edge to stay normal; powered after 16 clocks.
// - Mode after supply start is undefined until a frame has run; here srst selects shutdown.
// - Conversions no faster than one per twenty serial clock periods; not enforced here, the host paces frames.
// - Select fall releases the output and samples the input.
// - Frame is three zeros, ten result bits MSB first, two zeros.
// - Bits change on falling clock; host captures on the next rising edge.

`timescale 1ns/1ps
`default_nettype none

module sadc_frame_ctrl (
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   link_sclk,
   input  wire logic                   chip_sel_n,
   input  wire sadc_pkg::sadc_code_t   sample_code,
   output logic                        serial_result_out,
   output logic                        serial_result_oe_n,
   output logic                        analog_power_on,
   output logic                        sample_hold,
   output sadc_pkg::sadc_status_t      status
);

   // -------------------------------------------------------------------
   // Link domain: runs on the host serial clock
   // -------------------------------------------------------------------
   // Chip select acts asynchronously on the pin; it is treated as the
   // frame's own reset so that a rise ends the frame with no clock edge.
   logic [4:0]           fall_cnt_q;
   sadc_pkg::sadc_code_t shift_q;
   logic                 out_bit_q;
   logic                 out_en_q;
   logic                 frame_tog_q;
   logic                 frame_full_q;
   logic                 past_ten_q;

   // Count falling edges since the select fall; hold at the last edge.
   // Frame pacing is the host's; this count only shapes one frame.
   always_ff @(negedge link_sclk or posedge chip_sel_n) begin
      if (chip_sel_n) begin
         fall_cnt_q <= sadc_pkg::EDGE_CNT_RST;
      end else if (fall_cnt_q != sadc_pkg::EDGE_LAST) begin
         fall_cnt_q <= fall_cnt_q + 5'h0_1;
      end
   end

   // Shift out three zeros, the code MSB first, then zeros.
   always_ff @(negedge link_sclk or posedge chip_sel_n) begin
      if (chip_sel_n) begin
         shift_q   <= '0;
         out_bit_q <= 1'b0;
      end else if (fall_cnt_q == sadc_pkg::EDGE_CNT_RST) begin
         shift_q   <= sample_code;
         out_bit_q <= 1'b0;
      end else if (fall_cnt_q < sadc_pkg::EDGE_LEAD) begin
         out_bit_q <= 1'b0;
      end else begin
         out_bit_q <= shift_q[sadc_pkg::RES_BITS-1];
         shift_q   <= {shift_q[sadc_pkg::RES_BITS-2:0], 1'b0};
      end
   end

   // Output released at select fall, floated after the 16th falling edge
   // or at the select rise, whichever comes first.  The enable rests high
   // between frames so the release needs no serial clock edge; the select
   // term at the output stage keeps the pin floated meanwhile.
   always_ff @(negedge link_sclk or posedge chip_sel_n) begin
      if (chip_sel_n) begin
         out_en_q <= 1'b1;
      end else begin
         out_en_q <= (fall_cnt_q < (sadc_pkg::EDGE_LAST - 5'h0_1));
      end
   end

   // Reaching the tenth edge marks the frame as one that keeps normal mode.
   always_ff @(negedge link_sclk or posedge chip_sel_n) begin
      if (chip_sel_n) begin
         past_ten_q <= 1'b0;
      end else if (fall_cnt_q == (sadc_pkg::EDGE_SHUT - 5'h0_1)) begin
         past_ten_q <= 1'b1;
      end
   end

   always_ff @(negedge link_sclk or posedge chip_sel_n) begin
      if (chip_sel_n) begin
         frame_full_q <= 1'b0;
      end else if (fall_cnt_q == (sadc_pkg::EDGE_LAST - 5'h0_1)) begin
         frame_full_q <= 1'b1;
      end
   end

   // Toggle on the first edge of each frame so the system side sees it.
   always_ff @(negedge link_sclk or posedge srst) begin
      if (srst) begin
         frame_tog_q <= 1'b0;
      end else if (!chip_sel_n && fall_cnt_q == sadc_pkg::EDGE_CNT_RST) begin
         frame_tog_q <= ~frame_tog_q;
      end
   end

   // -------------------------------------------------------------------
   // Crossing into the system clock
   // -------------------------------------------------------------------
   logic [1:0] cs_sync_q;
   logic [1:0] ten_sync_q;
   logic [1:0] full_sync_q;
   logic [2:0] tog_sync_q;
   logic [1:0] bit_sync_q;
   logic [1:0] en_sync_q;

   always_ff @(posedge sys_clk) begin
      cs_sync_q   <= {cs_sync_q[0], chip_sel_n};
      ten_sync_q  <= {ten_sync_q[0], past_ten_q};
      full_sync_q <= {full_sync_q[0], frame_full_q};
      tog_sync_q  <= {tog_sync_q[1:0], frame_tog_q};
      bit_sync_q  <= {bit_sync_q[0], out_bit_q};
      en_sync_q   <= {en_sync_q[0], out_en_q};
   end

   logic cs_prev_q;
   logic ten_seen_q;
   logic full_seen_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_sync_q[1];
      end
   end

   wire cs_fall = cs_prev_q && !cs_sync_q[1];
   wire cs_rise = !cs_prev_q && cs_sync_q[1];

   // Latch the frame marks while select is low; they hold past the select rise and clear at the next select fall.
   always_ff @(posedge sys_clk) begin
      if (srst || cs_fall) begin
         ten_seen_q  <= 1'b0;
         full_seen_q <= 1'b0;
      end else begin
         if (ten_sync_q[1]) begin
            ten_seen_q <= 1'b1;
         end
         if (full_sync_q[1]) begin
            full_seen_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Power mode
   // -------------------------------------------------------------------
   // Start-up mode is undefined in silicon; shutdown is chosen here so
   // the first frame always counts as a power-up dummy.
   sadc_pkg::sadc_mode_t mode_q;
   logic                 warm_q;
   logic                 dummy_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_q <= sadc_pkg::SADC_MODE_SHUTDOWN;
      end else if (cs_fall) begin
         mode_q <= sadc_pkg::SADC_MODE_NORMAL;
      end else if (cs_rise && !ten_seen_q && !ten_sync_q[1]) begin
         mode_q <= sadc_pkg::SADC_MODE_SHUTDOWN;
      end
   end

   // Warm once a normal frame ran its 16 clocks after power-up.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         warm_q <= 1'b0;
      end else if (mode_q == sadc_pkg::SADC_MODE_SHUTDOWN && !cs_fall) begin
         warm_q <= 1'b0;
      end else if (full_seen_q && ten_seen_q) begin
         warm_q <= 1'b1;
      end
   end

   // The frame that wakes the core is a dummy; its result is not valid.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dummy_q <= 1'b1;
      end else if (cs_fall) begin
         dummy_q <= !warm_q;
      end
   end

   // -------------------------------------------------------------------
   // Registered outputs
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         serial_result_out  <= 1'b0;
         serial_result_oe_n <= 1'b1;
      end else begin
         serial_result_out  <= bit_sync_q[1];
         serial_result_oe_n <= !(en_sync_q[1] && !cs_sync_q[1]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         analog_power_on <= 1'b0;
         sample_hold     <= 1'b0;
         status          <= '0;
      end else begin
         analog_power_on     <= (mode_q == sadc_pkg::SADC_MODE_NORMAL);
         sample_hold         <= !cs_sync_q[1];
         status.normal_mode  <= (mode_q == sadc_pkg::SADC_MODE_NORMAL);
         status.powered      <= warm_q;
         status.result_valid <= !dummy_q && full_seen_q;
      end
   end

endmodule // sadc_frame_ctrl

`default_nettype wire

//--- hw/sadc_pkg.sv
// Shared constants and carrier types for the serial converter frame logic.
// Assumes a system clock of 25 MHz and a host-driven serial clock domain.

package sadc_pkg;

   // -------------------------------------------------------------------
   // Frame shape
   // -------------------------------------------------------------------
   localparam int unsigned RES_BITS      = 10;
   localparam int unsigned LEAD_ZEROS    = 3;
   localparam int unsigned FRAME_CYCLES  = 16;
   localparam int unsigned SHUTDOWN_EDGE = 10;
   localparam int unsigned CODE_STEPS    = 1024;

   localparam logic [4:0] EDGE_CNT_RST = 5'h0_0;
   localparam logic [4:0] EDGE_SHUT    = 5'h0_A;
   localparam logic [4:0] EDGE_LAST    = 5'h1_0;
   localparam logic [4:0] EDGE_LEAD    = 5'h0_3;

   // -------------------------------------------------------------------
   // Throughput and quiet interval
   // -------------------------------------------------------------------
   localparam int unsigned SCLK_PER_CONV = 20;
   localparam int unsigned QUIET_NS      = 50;
   localparam int unsigned SYS_CLK_MHZ   = 25;
   localparam int unsigned QUIET_CYC_RAW = (QUIET_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned QUIET_CYC     = (QUIET_CYC_RAW < 1) ? 1 : QUIET_CYC_RAW;

   typedef logic [RES_BITS-1:0] sadc_code_t;

   typedef enum logic [0:0] {
      SADC_MODE_SHUTDOWN = 1'b0,
      SADC_MODE_NORMAL   = 1'b1
   } sadc_mode_t;

   typedef struct packed {
      logic normal_mode;
      logic powered;
      logic result_valid;
   } sadc_status_t;

   typedef struct packed {
      logic serial_result_out;
      logic serial_result_oe_n;
   } sadc_pin_t;

endpackage
